/* File: rtl/wwdt_consts.svh */
/*
 * constants of the windowed watchdog: register offsets, field positions,
 * reset values and tick counts.
 * assumes nothing; included by bare name from every design file except the types package.
 */
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define WWDT_CTRL_OFS      2'h0
`define WWDT_STAT_OFS      2'h1
`define WWDT_CTRL_RST      8'h00
`define WWDT_STAT_RST      8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WWDT_PER_LSB       0
`define WWDT_PER_MSB       3
`define WWDT_WIN_LSB       4
`define WWDT_WIN_MSB       7
`define WWDT_LOCK_BIT      7
`define WWDT_BUSY_BIT      0

// ----------------------------------------------------------------------
// codes and tick counts
// ----------------------------------------------------------------------
`define WWDT_CODE_OFF      4'h0
`define WWDT_CODE_MAX      4'hB
`define WWDT_TICK_HZ       1024
`define WWDT_BASE_TICKS    16'h0008
`define WWDT_SYNC_TICKS    2'h2
`define WWDT_UNLOCK_INSTRS 3'h4

`endif

/* File: rtl/wwdt_pkg.sv */
/*
 * types of the windowed watchdog: window phase and the state records
 * of each module.
 * assumes the constants header for nothing; holds types only.
 */
package wwdt_pkg;

    // window phase of the counter
    typedef enum logic [1:0] {
        WWDT_IDLE,
        WWDT_CLOSED,
        WWDT_OPEN
    } wwdt_phase_t;

    // state of the tick-domain hand-over
    typedef struct packed {
        logic       busy;
        logic [1:0] cnt;
        logic       done;
    } wwdt_sync_t;

    // state of the unlock window
    typedef struct packed {
        logic       open;
        logic [2:0] cnt;
    } wwdt_unlock_t;

    // state of the watchdog core
    typedef struct packed {
        logic        booted;
        logic [7:0]  ctrl;
        logic        lock;
        logic [7:0]  pend;
        logic [3:0]  act_per;
        logic [3:0]  act_win;
        wwdt_phase_t phase;
        logic        armed;
        logic [15:0] count;
        logic        fired;
        logic        tick_q;
        logic [7:0]  rdata;
    } wwdt_core_t;

endpackage

/* File: rtl/wwdt_tick_sync.sv */
/*
 * hands a one-cycle request over to the watchdog tick: done pulses in the cycle after
 * the tick that completes the count of sync ticks after the request.
 * assumes i_tick is a one-cycle pulse per watchdog tick.
 */
`timescale 1ns/1ps
`include "wwdt_consts.svh"

module wwdt_tick_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_req,
    input  wire logic i_tick,
    output logic      o_busy,
    output logic      o_done
);
    wwdt_pkg::wwdt_sync_t st;
    wwdt_pkg::wwdt_sync_t next_st;

    // ------------------------------------------------------------------
    // count ticks while busy; a request while busy merges with it
    // ------------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            if (i_tick) begin
                if (st.cnt == `WWDT_SYNC_TICKS - 2'h1) begin
                    // a request in the closing cycle starts a new hand-over
                    next_st.busy = i_req;
                    next_st.done = 1'b1;
                    next_st.cnt  = 2'h0;
                end else begin
                    next_st.cnt = st.cnt + 2'h1;
                end
            end
        end else if (i_req) begin
            next_st.busy = 1'b1;
            next_st.cnt  = 2'h0;
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_busy = st.busy;
    assign o_done = st.done;
endmodule // wwdt_tick_sync

/* File: rtl/wwdt_top.sv */
/*
 * windowed watchdog timer: control and status registers, protected
 * writes, lock, fuse load at boot, hand-over of control writes and restarts to
 * the watchdog tick, normal and window time-out, debug halt handling.
 * assumes all inputs synchronous to I_REF_CLK; I_WDT_TICK is the slow
 * oscillator level, sampled here and edge detected.
 */
// Functional notes
// R1: non-zero period field enables the watchdog; zero keeps it off.
// R2: non-zero window field selects window mode; zero selects normal mode.
// R3: control register and lock bit accept writes only through unlock.
// R4: fuse loads control at boot; non-zero period also sets lock.
// R5: counter advances on the slow watchdog tick only.
// R6: normal mode resets the system when no restart comes in time.
// R7: each restart clears the counter and starts a fresh period.
// R8: period codes 1 to 11 double from eight ticks; zero off.
// R9: restart during the closed window resets the system.
// R10: open period follows closed period; restart needed within it.
// R11: closed window applies only after the first restart once enabled.
// R12: window codes use the same doubling encoding as period codes.
// R13: lock can only be set; cleared in debug only; freezes control.
// R14: counting continues in sleep while the tick runs.
// R15: debug halt stops the watchdog and clears its counter.
// R16: after debug halt the first closed window is skipped.
// R17: control writes pass to tick domain; sync_pending shows it.
// R18: software must not write control while sync_pending is one.
// R19: restart reaches the counter within two to three ticks.
// R20: unlock key then protected write within four instructions.
// R21: protected write without unlock is ignored.
// R22: sync_pending sets on control write, clears when done, read-only.
// R23: code n gives eight shifted left by n minus one ticks.
`timescale 1ns/1ps
`include "wwdt_consts.svh"

module wwdt_top (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST,
    input  wire logic [1:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    input  wire logic       I_UNLOCK_KEY,
    input  wire logic       I_INSTR_RETIRE,
    input  wire logic       I_RESTART,
    input  wire logic       I_WDT_TICK,
    input  wire logic       I_DEBUG_MODE,
    input  wire logic       I_DEBUG_HALT,
    input  wire logic [7:0] I_FUSE_CONFIG,
    output logic            O_SYS_RESET
);
    wwdt_pkg::wwdt_core_t st;
    wwdt_pkg::wwdt_core_t next_st;

    logic tick;
    logic unlock_open;
    logic ctrl_wr;
    logic stat_wr;
    logic ctrl_take;
    logic prot_used;
    logic sync_busy;
    logic sync_done;
    logic rst_done;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // ticks of a period or window code; reserved codes act as the longest
    function automatic logic [15:0] code_ticks(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `WWDT_CODE_MAX) ? `WWDT_CODE_MAX : code;
        code_ticks = `WWDT_BASE_TICKS << (c - 4'h1); // R8 R12 R23
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // tick edge and write decode
    assign tick      = I_WDT_TICK & ~st.tick_q; // R5
    assign ctrl_wr   = I_WR && (I_ADDR == `WWDT_CTRL_OFS);
    assign stat_wr   = I_WR && (I_ADDR == `WWDT_STAT_OFS);
    // control write lands only when unlocked, not locked, not syncing
    assign ctrl_take = ctrl_wr && unlock_open && !st.lock && !sync_busy; // R3 R13 R21
    assign prot_used = (ctrl_wr || stat_wr) && unlock_open; // R20

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------

    // change-protection window
    wwdt_unlock u_unlock (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_key   (I_UNLOCK_KEY),
        .i_instr (I_INSTR_RETIRE),
        .i_used  (prot_used),
        .o_open  (unlock_open)
    );

    // control write hand-over to the tick
    wwdt_tick_sync u_ctrl_sync (
        .i_clk  (I_REF_CLK),
        .i_rst  (I_RST),
        .i_req  (ctrl_take),
        .i_tick (tick),
        .o_busy (sync_busy),
        .o_done (sync_done)
    );

    // restart hand-over to the tick
    wwdt_tick_sync u_rst_sync (
        .i_clk  (I_REF_CLK),
        .i_rst  (I_RST),
        .i_req  (I_RESTART),
        .i_tick (tick),
        .o_busy (),
        .o_done (rst_done)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.tick_q = I_WDT_TICK;

        // boot: load fuse into control and active fields
        if (!st.booted) begin
            next_st.booted  = 1'b1;
            next_st.ctrl    = I_FUSE_CONFIG; // R4
            next_st.act_per = I_FUSE_CONFIG[`WWDT_PER_MSB:`WWDT_PER_LSB];
            next_st.act_win = I_FUSE_CONFIG[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
            next_st.lock    = (I_FUSE_CONFIG[`WWDT_PER_MSB:`WWDT_PER_LSB]
                               != `WWDT_CODE_OFF); // R4
        end

        // protected control write: visible at once, active after sync
        if (ctrl_take) begin
            next_st.ctrl = I_WDATA; // R17
            next_st.pend = I_WDATA;
        end

        // lock: set only, clear only in debug mode, always under unlock
        if (stat_wr && unlock_open) begin // R3 R21
            if (I_WDATA[`WWDT_LOCK_BIT]) begin
                next_st.lock = 1'b1; // R13
            end else if (I_DEBUG_MODE) begin
                next_st.lock = 1'b0; // R13
            end
        end

        // synced fields take effect in the tick domain
        if (sync_done) begin
            next_st.act_per = st.pend[`WWDT_PER_MSB:`WWDT_PER_LSB]; // R17
            next_st.act_win = st.pend[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
            // entering window mode: wait for a restart first
            if (st.act_win == `WWDT_CODE_OFF
                && st.pend[`WWDT_WIN_MSB:`WWDT_WIN_LSB] != `WWDT_CODE_OFF) begin
                next_st.armed = 1'b0; // R11
            end
        end

        // ------------------------------------------------------------
        // counter
        // ------------------------------------------------------------
        if (st.act_per == `WWDT_CODE_OFF || I_DEBUG_HALT) begin
            // off or halted: counter cleared, first window skipped
            next_st.count = 16'h0000; // R1 R15
            next_st.phase = wwdt_pkg::WWDT_IDLE;
            next_st.armed = 1'b0; // R16
        end else if (rst_done) begin
            if (st.phase == wwdt_pkg::WWDT_CLOSED) begin
                next_st.fired = 1'b1; // R9
            end else begin
                next_st.count = 16'h0000; // R7 R19
                if (st.act_win != `WWDT_CODE_OFF) begin
                    next_st.phase = wwdt_pkg::WWDT_CLOSED; // R2 R10
                    next_st.armed = 1'b1;
                end else begin
                    next_st.phase = wwdt_pkg::WWDT_OPEN;
                end
            end
        end else begin
            unique case (st.phase)
                wwdt_pkg::WWDT_IDLE: begin
                    // enabled: a normal period runs first
                    next_st.phase = wwdt_pkg::WWDT_OPEN; // R11 R16
                    next_st.count = 16'h0000;
                end
                wwdt_pkg::WWDT_CLOSED: begin
                    if (tick) begin // R14
                        if (st.count + 16'h0001 >= code_ticks(st.act_win)) begin
                            next_st.phase = wwdt_pkg::WWDT_OPEN; // R10
                            next_st.count = 16'h0000;
                        end else begin
                            next_st.count = st.count + 16'h0001;
                        end
                    end
                end
                wwdt_pkg::WWDT_OPEN: begin
                    if (tick) begin
                        if (st.count + 16'h0001 >= code_ticks(st.act_per)) begin
                            next_st.fired = 1'b1; // R6 R10
                        end else begin
                            next_st.count = st.count + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_st.phase = wwdt_pkg::WWDT_IDLE;
                end
            endcase
        end

        // window mode left: no closed window pending
        if (st.act_win == `WWDT_CODE_OFF && st.phase == wwdt_pkg::WWDT_CLOSED) begin
            next_st.phase = wwdt_pkg::WWDT_OPEN; // R2
        end

        // ------------------------------------------------------------
        // read data, valid the cycle after the strobe
        // ------------------------------------------------------------
        next_st.rdata = 8'h00;
        if (I_RD) begin
            unique case (I_ADDR)
                `WWDT_CTRL_OFS: next_st.rdata = st.ctrl;
                `WWDT_STAT_OFS: begin
                    next_st.rdata[`WWDT_LOCK_BIT] = st.lock;
                    next_st.rdata[`WWDT_BUSY_BIT] = sync_busy; // R22
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            st       <= '0;
            st.ctrl  <= `WWDT_CTRL_RST;
            st.pend  <= `WWDT_CTRL_RST;
            st.phase <= wwdt_pkg::WWDT_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign O_RDATA     = st.rdata;
    assign O_SYS_RESET = st.fired; // held until I_RST
endmodule // wwdt_top

/* File: rtl/wwdt_unlock.sv */
/*
 * change-protection window: opens on the unlock key, stays open for a
 * fixed number of retired instructions or until one protected write.
 * assumes the key and retire inputs are one-cycle pulses.
 */
`timescale 1ns/1ps
`include "wwdt_consts.svh"

module wwdt_unlock (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_key,
    input  wire logic i_instr,
    input  wire logic i_used,
    output logic      o_open
);
    wwdt_pkg::wwdt_unlock_t st;
    wwdt_pkg::wwdt_unlock_t next_st;

    // ------------------------------------------------------------------
    // window control; a fresh key restarts the count
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (i_key) begin
            next_st.open = 1'b1;
            next_st.cnt  = 3'h0;
        end else if (st.open) begin
            if (i_used) begin
                next_st.open = 1'b0;
            end else if (i_instr) begin
                next_st.cnt = st.cnt + 3'h1;
                if (st.cnt + 3'h1 >= `WWDT_UNLOCK_INSTRS) begin
                    next_st.open = 1'b0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_open = st.open;
endmodule // wwdt_unlock

/* File: testbench/testbench.sv */
/*
 * bench of the windowed watchdog: register tasks, cpu model, fast tick.
 * assumes the design, the cpu model and the checker.
 */
`timescale 1ns/1ps

module testbench;
    localparam int TK = 8; // reference clocks per tick
    logic       I_REF_CLK;
    logic       I_RST;
    logic [1:0] I_ADDR;
    logic [7:0] I_WDATA;
    logic       I_WR;
    logic       I_RD;
    logic       I_WDT_TICK;
    logic       I_DEBUG_MODE;
    logic       I_DEBUG_HALT;
    logic [7:0] I_FUSE_CONFIG;
    logic [7:0] O_RDATA;
    logic       O_SYS_RESET;
    logic       I_UNLOCK_KEY;
    logic       I_INSTR_RETIRE;
    logic       I_RESTART;
    logic [2:0] tcnt          = 3'h0;
    int         mismatches    = 0;
    int         n_compared    = 0;
    int         cycles        = 0;
    int         per;
    int         codes [4]     = '{1, 2, 3, 11};

    wwdt_cpu_model cpu (.i_clk(I_REF_CLK), .o_key(I_UNLOCK_KEY), .o_retire(I_INSTR_RETIRE),
                        .o_restart(I_RESTART));
    wwdt_top uut (.I_REF_CLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_UNLOCK_KEY,
                  .I_INSTR_RETIRE, .I_RESTART, .I_WDT_TICK, .I_DEBUG_MODE, .I_DEBUG_HALT,
                  .I_FUSE_CONFIG, .O_SYS_RESET);

    // ------------------------------------------------------------
    // clock, tick and time limit
    // ------------------------------------------------------------
    // reference clock
    initial begin
        I_REF_CLK = 1'h0;
        forever #2 I_REF_CLK = ~I_REF_CLK;
    end

    // slow tick level, one rising edge every TK clocks
    assign I_WDT_TICK = tcnt[2];

    // tick divider and cycle ceiling
    always @(posedge I_REF_CLK) begin
        tcnt <= tcnt + 3'h1;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // verdict and end of run
    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one comparison
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // wait whole ticks
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge I_REF_CLK);
    endtask

    // register write, one cycle
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'h1;
        @(posedge I_REF_CLK);
        I_WR <= 1'h0;
    endtask

    // register read; data checked in the following cycle
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        I_ADDR <= a;
        I_RD <= 1'h1;
        @(posedge I_REF_CLK);
        I_RD <= 1'h0;
        @(negedge I_REF_CLK);
        check(O_RDATA, exp);
        @(posedge I_REF_CLK);
    endtask

    // system reset request level
    task automatic chk_reset(input logic exp);
        @(negedge I_REF_CLK);
        check({7'h00, O_SYS_RESET}, {7'h00, exp});
        @(posedge I_REF_CLK);
    endtask

    // reset with a given fuse value
    task automatic do_reset(input logic [7:0] fuse);
        I_FUSE_CONFIG <= fuse;
        I_RST <= 1'h1;
        repeat (3) @(posedge I_REF_CLK);
        I_RST <= 1'h0;
        repeat (2) @(posedge I_REF_CLK);
    endtask

    // protected control write, then wait for the hand-over
    task automatic prog(input logic [7:0] d);
        cpu.unlock(0);
        wr(2'h0, d);
        ticks(4);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // idle levels from time zero, reset held
        I_RST         <= 1'h1;
        I_ADDR        <= 2'h0;
        I_WDATA       <= 8'h00;
        I_WR          <= 1'h0;
        I_RD          <= 1'h0;
        I_DEBUG_MODE  <= 1'h0;
        I_DEBUG_HALT  <= 1'h0;
        I_FUSE_CONFIG <= 8'h00;
        @(posedge I_REF_CLK);
        do_reset(8'h00);
        // unprotected writes, unmapped place, disabled watchdog
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'h05);
        rd(2'h0, 8'h00);
        wr(2'h1, 8'h80);
        rd(2'h1, 8'h00);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'h00);
        ticks(24);
        chk_reset(1'h0);
        // lock set, control frozen, clear only in debug
        cpu.unlock(0);
        wr(2'h1, 8'h80);
        rd(2'h1, 8'h80);
        cpu.unlock(0);
        wr(2'h0, 8'h03);
        rd(2'h0, 8'h00);
        cpu.unlock(0);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h80);
        I_DEBUG_MODE <= 1'h1;
        cpu.unlock(0);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h00);
        I_DEBUG_MODE <= 1'h0;
        // unlock window length, busy flag, write while busy
        cpu.unlock(4);
        wr(2'h0, 8'h02);
        rd(2'h0, 8'h00);
        cpu.unlock(3);
        wr(2'h0, 8'h02);
        rd(2'h1, 8'h01);
        cpu.unlock(0);
        wr(2'h0, 8'h03);
        rd(2'h0, 8'h02);
        ticks(4);
        rd(2'h1, 8'h00);
        // period per code: restarts keep it alive, silence fires it
        foreach (codes[i]) begin
            per = 8 << (codes[i] - 1);
            do_reset(8'h00);
            prog(8'(codes[i]));
            repeat (4) begin
                cpu.restart();
                ticks(5);
            end
            chk_reset(1'h0);
            cpu.restart();
            ticks(per);
            chk_reset(1'h0);
            ticks(4);
            chk_reset(1'h1);
        end
        // window mode: first restart free, open restarts, closed restart
        do_reset(8'h00);
        prog(8'h11);
        cpu.restart();
        ticks(12);
        chk_reset(1'h0);
        cpu.restart();
        ticks(12);
        cpu.restart();
        ticks(3);
        chk_reset(1'h0);
        cpu.restart();
        ticks(5);
        chk_reset(1'h1);
        // reserved window code acts as the longest: second restart is early
        do_reset(8'h00);
        prog(8'hC1);
        cpu.restart();
        ticks(12);
        chk_reset(1'h0);
        cpu.restart();
        ticks(5);
        chk_reset(1'h1);
        // debug halt, then the first closed window is skipped
        do_reset(8'h00);
        prog(8'h11);
        cpu.restart();
        ticks(4);
        I_DEBUG_HALT <= 1'h1;
        ticks(30);
        chk_reset(1'h0);
        I_DEBUG_HALT <= 1'h0;
        ticks(1);
        cpu.restart();
        ticks(5);
        chk_reset(1'h0);
        // fuse boot: enabled, locked, fires without restarts
        do_reset(8'h21);
        rd(2'h0, 8'h21);
        rd(2'h1, 8'h80);
        ticks(12);
        chk_reset(1'h1);
        report_and_stop();
    end
endmodule // testbench

bind wwdt_top wwdt_top_sva sva (.I_REF_CLK, .I_RST, .I_ADDR, .I_RD, .O_RDATA, .I_WDT_TICK,
                                .I_DEBUG_MODE, .I_DEBUG_HALT, .O_SYS_RESET);

/* File: testbench/wwdt_cpu_model.sv */
/*
 * processor side: unlock key, retired instructions, restarts.
 * assumes its tasks are entered just after a rising edge.
 */
`timescale 1ns/1ps

module wwdt_cpu_model (
    input  wire logic i_clk,
    output logic      o_key,
    output logic      o_retire,
    output logic      o_restart
);
    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    // idle levels from time zero
    initial begin
        o_key = 1'h0;
        o_retire = 1'h0;
        o_restart = 1'h0;
    end

    // key, then gap instructions before the protected write
    task automatic unlock(input int gap);
        o_key <= 1'h1;
        @(posedge i_clk);
        o_key <= 1'h0;
        repeat (gap) begin
            o_retire <= 1'h1;
            @(posedge i_clk);
            o_retire <= 1'h0;
            @(posedge i_clk);
        end
    endtask

    // one restart instruction
    task automatic restart();
        o_restart <= 1'h1;
        @(posedge i_clk);
        o_restart <= 1'h0;
    endtask
endmodule // wwdt_cpu_model

/* File: testbench/wwdt_top_sva.sv */
/*
 * checker of the windowed watchdog on its top ports.
 * assumes a fast tick of a few reference clocks per period.
 */
`timescale 1ns/1ps

module wwdt_top_sva (
    input wire logic       I_REF_CLK,
    input wire logic       I_RST,
    input wire logic [1:0] I_ADDR,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic       I_WDT_TICK,
    input wire logic       I_DEBUG_MODE,
    input wire logic       I_DEBUG_HALT,
    input wire logic       O_SYS_RESET
);
    logic [3:0] since_tick;
    logic       lock_seen;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // age of the last tick edge; lock seen set outside debug
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            since_tick <= 4'hF;
            lock_seen  <= 1'h0;
        end else begin
            if ($rose(I_WDT_TICK)) begin
                since_tick <= 4'h0;
            end else if (since_tick != 4'hF) begin
                since_tick <= since_tick + 4'h1;
            end
            if (I_DEBUG_MODE) begin
                lock_seen <= 1'h0;
            end else if ($past(I_RD) && $past(I_ADDR) == 2'h1 && O_RDATA[7]) begin
                lock_seen <= 1'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence stat_read;
        I_RD && I_ADDR == 2'h1;
    endsequence
    sequence halted_quiet;
        (I_DEBUG_HALT && !O_SYS_RESET) [*3];
    endsequence

    AST_RESET_HELD: assert property (O_SYS_RESET |=> O_SYS_RESET)
        else $error("reset request dropped");
    AST_FIRE_ON_TICK: assert property ($rose(O_SYS_RESET) |-> since_tick <= 4'h2)
        else $error("reset request away from a tick edge");
    AST_HALT_QUIET: assert property (halted_quiet |=> !O_SYS_RESET)
        else $error("reset request while halted");
    AST_BOOT_QUIET: assert property ($fell(I_RST) |-> !O_SYS_RESET ##1 !O_SYS_RESET)
        else $error("reset request right after boot");
    AST_STATUS_SPARE: assert property (stat_read |=> O_RDATA[6:1] == 6'h00)
        else $error("status spare bits not zero");
    AST_UNMAPPED_ZERO: assert property (I_RD && I_ADDR[1] |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_IDLE_ZERO: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside its slot");
    AST_LOCK_KEPT: assert property ((lock_seen && !I_DEBUG_MODE) ##0 stat_read |=> O_RDATA[7])
        else $error("lock cleared outside debug");
endmodule // wwdt_top_sva
